// ### txfb_pkg.sv
`default_nettype none
package txfb_pkg;
	// ***********************************************
	// Register map (byte addresses, word aligned)
	// ***********************************************
	localparam logic [7:0] TXFB_TX_CONFIG_OFS = 8'h2C;
	localparam logic [7:0] TXFB_RX_DESC_PTR_OFS = 8'h30;
	localparam logic [7:0] TXFB_STATUS_OFS = 8'h38;
	localparam logic [7:0] TXFB_SOFT_RESET_OFS = 8'h3C;
	localparam logic [31:0] TXFB_TX_CONFIG_RST = 32'h0000_0000;
	localparam logic [31:0] TXFB_RX_DESC_PTR_RST = 32'h0000_0000;
	localparam logic [31:0] TXFB_TX_CONFIG_MASK = 32'h0070_3F3F;
	localparam logic [31:0] TXFB_BAD_READ = 32'hDEAD_BEEF;
	// ***********************************************
	// Field positions
	// ***********************************************
	localparam int TXFB_BURST_LSB = 20;
	localparam int TXFB_FILL_LSB = 8;
	localparam int TXFB_DRAIN_LSB = 0;
	// ***********************************************
	// Sizes: 32-byte threshold units, 4-byte words
	// ***********************************************
	localparam int TXFB_UNIT_BYTES = 32;
	localparam int TXFB_WORD_BYTES = 4;
	localparam int TXFB_CAPACITY_BYTES = 2048;
	localparam int TXFB_CNT_W = 12;
	localparam int TXFB_BURST_ZERO_WORDS = 128;
	localparam int TXFB_STAGE_DEPTH = 2;
endpackage
`default_nettype wire

// ### txfb_skid.sv
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer, full throughput, no word lost on stall
module txfb_skid
	import txfb_pkg::*;
#(
	parameter int WIDTH = 33
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] mem_r [TXFB_STAGE_DEPTH];
	logic wp_r;
	logic rp_r;
	logic [1:0] cnt_r;
	logic in_ready_r;
	logic out_valid_r;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	wire [1:0] cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

	// Flags taken from the next count, so both ports come from flops
	assign in_ready_o = in_ready_r;
	assign out_valid_o = out_valid_r;
	assign out_data_o = mem_r[rp_r];

	// Pointers and count
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'd0;
			in_ready_r <= 1'b1;
			out_valid_r <= 1'b0;
		end
		else
		begin
			if (push)
				wp_r <= ~wp_r;
			if (pop)
				rp_r <= ~rp_r;
			cnt_r <= cnt_nxt;
			in_ready_r <= (cnt_nxt != 2'd2);
			out_valid_r <= (cnt_nxt != 2'd0);
		end
	end

	// Storage needs no reset
	always_ff @(posedge sys_clk_i)
	begin
		if (push)
			mem_r[wp_r] <= in_data_i;
	end
endmodule // txfb_skid
`default_nettype wire

// ### txfb_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module txfb_ctl
	import txfb_pkg::*;
#(
	parameter int CAPACITY_BYTES = TXFB_CAPACITY_BYTES
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Fetch side: data words from the bus master
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_last_i,
	// Bus master permission and burst cap
	output logic fetch_grant_o,
	output logic [7:0] burst_words_o,
	// MAC transmit engine side
	output logic tx_start_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [31:0] rd_data_o,
	output logic rd_last_o
);
	// Pointer and counter widths serve only the 2048-byte store
	if (CAPACITY_BYTES != TXFB_CAPACITY_BYTES)
	begin : g_capacity_check
		$error("txfb_ctl: store pointers serve only a 2048-byte capacity");
	end

	// ***********************************************
	// Register file
	// ***********************************************
	logic [31:0] tx_config_r;
	logic [31:0] rx_descriptor_pointer_r;
	logic [31:0] avs_readdata_r;
	logic ack_r;
	logic wait_r;
	logic [31:0] wmask;
	wire req = (avs_read_i || avs_write_i) && !ack_r;
	// Writes land only at the edge that completes the transfer
	wire wr_cfg = avs_write_i && ack_r && (avs_address_i == TXFB_TX_CONFIG_OFS);
	wire wr_desc_ptr = avs_write_i && ack_r && (avs_address_i == TXFB_RX_DESC_PTR_OFS);
	wire wr_soft = avs_write_i && ack_r && (avs_address_i == TXFB_SOFT_RESET_OFS)
		&& avs_writedata_i[0] && avs_byteenable_i[0];

	// Byte enables to a bit mask
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction
	assign wmask = be_mask(avs_byteenable_i);

	// Field extraction
	wire [2:0] burst_code = tx_config_r[TXFB_BURST_LSB +: 3];
	wire [5:0] fill_units = tx_config_r[TXFB_FILL_LSB +: 6];
	wire [5:0] drain_units = tx_config_r[TXFB_DRAIN_LSB +: 6];

	// ***********************************************
	// Buffer occupancy and packet tracking
	// ***********************************************
	logic [TXFB_CNT_W-1:0] bytes_r;
	logic [7:0] pkts_r;
	logic tx_start_r;
	logic fetch_grant_r;
	logic [7:0] burst_words_r;
	logic sk_in_ready;
	logic sk_out_valid;
	logic [32:0] sk_out_data;
	logic main_valid;
	logic [31:0] mem_r [CAPACITY_BYTES/TXFB_WORD_BYTES];
	logic [8:0] wp_r;
	logic [8:0] rp_r;
	logic rd_valid_r;
	logic [31:0] rd_data_r;
	logic rd_last_r;

	// Stage stalls when main store full (back-pressure to the fetch side)
	wire store_full = (bytes_r == TXFB_CNT_W'(CAPACITY_BYTES));
	wire push = sk_out_valid && !store_full;
	logic last_mem_r [CAPACITY_BYTES/TXFB_WORD_BYTES];
	wire pop = main_valid && rd_ready_i;
	assign main_valid = (bytes_r != '0);
	wire pop_last = pop && last_mem_r[rp_r];
	wire push_last = push && sk_out_data[32];

	// Input stage absorbs the word in flight when the store stalls
	txfb_skid #(.WIDTH(33)) u_stage (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.in_valid_i(wr_valid_i),
		.in_ready_o(sk_in_ready),
		.in_data_i({wr_last_i, wr_data_i}),
		.out_valid_o(sk_out_valid),
		.out_ready_i(!store_full),
		.out_data_o(sk_out_data)
	);
	assign wr_ready_o = sk_in_ready;

	// Threshold decode, all in bytes
	wire [TXFB_CNT_W-1:0] free_bytes = TXFB_CNT_W'(CAPACITY_BYTES) - bytes_r;
	wire [TXFB_CNT_W-1:0] fill_bytes = TXFB_CNT_W'({fill_units, 5'b0});
	wire [TXFB_CNT_W-1:0] drain_bytes = TXFB_CNT_W'({drain_units, 5'b0});
	wire fill_ok = (free_bytes >= fill_bytes);
	wire drain_ok = (bytes_r >= drain_bytes) || (pkts_r != 8'd0);
	// Code 000 means the largest burst, else 1 << (code-1)
	wire [7:0] burst_dec = (burst_code == 3'd0) ? 8'(TXFB_BURST_ZERO_WORDS)
		: 8'(8'd1 << (burst_code - 3'd1));

	// ***********************************************
	// Registers
	// ***********************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i || wr_soft)
		begin
			tx_config_r <= TXFB_TX_CONFIG_RST;
			rx_descriptor_pointer_r <= TXFB_RX_DESC_PTR_RST;
		end
		else
		begin
			if (wr_cfg) // Unused bits never stored
				tx_config_r <= (tx_config_r & ~wmask)
					| (avs_writedata_i & wmask & TXFB_TX_CONFIG_MASK);
			if (wr_desc_ptr)
				rx_descriptor_pointer_r <= (rx_descriptor_pointer_r & ~wmask)
					| (avs_writedata_i & wmask);
		end
	end

	// Read mux
	wire [31:0] rd_mux = (avs_address_i == TXFB_TX_CONFIG_OFS) ? tx_config_r
		: (avs_address_i == TXFB_RX_DESC_PTR_OFS) ? rx_descriptor_pointer_r
		: (avs_address_i == TXFB_STATUS_OFS) ? {pkts_r, 8'h00, 4'h0, bytes_r}
		: (avs_address_i == TXFB_SOFT_RESET_OFS) ? 32'h0000_0000
		: TXFB_BAD_READ;

	// One wait state: answer the cycle after the request appears
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			ack_r <= 1'b0;
			wait_r <= 1'b1;
			avs_readdata_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r <= req;
			wait_r <= !req; // Kept as its own flop so the port needs no gate
			if (req && avs_read_i)
				avs_readdata_r <= rd_mux;
		end
	end
	assign avs_waitrequest_o = wait_r;
	assign avs_readdata_o = avs_readdata_r;

	// ***********************************************
	// Main store, byte count, packet count
	// ***********************************************
	// Next head and count, shared by the store and its output flops
	wire [8:0] rp_nxt = rp_r + {8'd0, pop};
	wire [TXFB_CNT_W-1:0] bytes_nxt = bytes_r + (push ? TXFB_CNT_W'(TXFB_WORD_BYTES) : '0)
		- (pop ? TXFB_CNT_W'(TXFB_WORD_BYTES) : '0);
	// A word written where the head lands next must bypass the array
	wire head_bypass = push && (wp_r == rp_nxt);
	wire [32:0] head_nxt = head_bypass ? sk_out_data : {last_mem_r[rp_nxt], mem_r[rp_nxt]};

	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			wp_r <= '0;
			rp_r <= '0;
			bytes_r <= '0;
			pkts_r <= 8'd0;
			rd_valid_r <= 1'b0;
			rd_last_r <= 1'b0;
		end
		else
		begin
			if (push)
				wp_r <= wp_r + 9'd1;
			rp_r <= rp_nxt;
			bytes_r <= bytes_nxt;
			pkts_r <= pkts_r + {7'd0, push_last} - {7'd0, pop_last};
			rd_valid_r <= (bytes_nxt != '0);
			rd_last_r <= head_nxt[32];
		end
	end

	// Storage array and show-ahead head word
	always_ff @(posedge sys_clk_i)
	begin
		if (push)
		begin
			mem_r[wp_r] <= sk_out_data[31:0];
			last_mem_r[wp_r] <= sk_out_data[32];
		end
		rd_data_r <= head_nxt[31:0];
	end
	assign rd_valid_o = rd_valid_r;
	assign rd_data_o = rd_data_r;
	assign rd_last_o = rd_last_r;

	// Registered control outputs
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			fetch_grant_r <= 1'b0;
			tx_start_r <= 1'b0;
			burst_words_r <= 8'(TXFB_BURST_ZERO_WORDS);
		end
		else
		begin
			fetch_grant_r <= fill_ok;
			tx_start_r <= drain_ok && main_valid;
			burst_words_r <= burst_dec;
		end
	end
	assign fetch_grant_o = fetch_grant_r;
	assign tx_start_o = tx_start_r;
	assign burst_words_o = burst_words_r;
endmodule // txfb_ctl
`default_nettype wire

// ### txfb_ctl_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the threshold block
module txfb_ctl_props
	import txfb_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Register bus
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Flags and MAC stream
	input wire logic fetch_grant_o,
	input wire logic [7:0] burst_words_o,
	input wire logic tx_start_o,
	input wire logic rd_valid_o,
	input wire logic rd_last_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	// Accepted config write, then the cap it sets
	sequence cfg_wr_s;
		avs_write_i && !avs_waitrequest_o && avs_address_i == TXFB_TX_CONFIG_OFS;
	endsequence
	property cap_p;
		logic [2:0] c;
		(cfg_wr_s, c = avs_writedata_i[22:20]) |->
			##2 burst_words_o == (c == 3'h0 ? 8'h80 : 8'h01 << (c - 3'h1));
	endproperty
	burst_cap_a: assert property (cap_p)
		else $error("burst cap wrong");
	unused_zero_a: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i == TXFB_TX_CONFIG_OFS |-> (avs_readdata_o & ~TXFB_TX_CONFIG_MASK) == 32'h0)
		else $error("unused bits set");
	// An empty store always leaves room, since the fill level tops out below capacity
	grant_room_a: assert property (!fetch_grant_o && $past(resetn_i, 2) |-> $past(rd_valid_o))
		else $error("grant low while empty");
	// Start only with data, always with a whole packet
	start_data_a: assert property (tx_start_o |-> $past(rd_valid_o))
		else $error("start while empty");
	start_pkt_a: assert property ((rd_valid_o && rd_last_o) [*2] |-> tx_start_o)
		else $error("packet held, no start");
endmodule // txfb_ctl_props
`default_nettype wire

// ### txfb_far.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master and MAC engine stand-in
module txfb_far
(
	// Clock, reset, control
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic run_i,
	input wire logic drain_i,
	// Streams
	input wire logic grant_i,
	input wire logic wr_ready_i,
	output logic wr_valid_o,
	output logic [31:0] wr_data_o,
	output logic wr_last_o,
	output logic rd_ready_o
);
	// Four-word packets; drain pacing comes from the bench
	assign wr_last_o = wr_data_o[1:0] == 2'h3;
	assign rd_ready_o = drain_i;
	// Word held until taken; new words only while granted
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
			wr_valid_o <= 1'b0;
		else if (!wr_valid_o || wr_ready_i)
			wr_valid_o <= run_i && grant_i;
	end
	// Counting pattern, so any loss or reorder shows
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
			wr_data_o <= 32'h0;
		else if (wr_valid_o && wr_ready_i)
			wr_data_o <= wr_data_o + 32'h1;
	end
endmodule // txfb_far
`default_nettype wire

// ### tx_fifo_threshold_burst_ctl_test.sv
`timescale 1ns/1ps
`default_nettype none
module tx_fifo_threshold_burst_ctl_test
	import txfb_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic run = 1'b0;
	logic drain = 1'b0;
	logic [7:0] adr = 8'h0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] q, rdata, wdat, rdat;
	logic wreq, wv, wrdy, wlast, grant, start, rv, rrdy, rlast;
	logic [7:0] bw;
	logic [32:0] exp_q[$];
	int seed = 66;
	int bad_count = 0;
	int n_checks = 0;
	int i, c;
	txfb_ctl u_txfb_ctl (.sys_clk_i(clk), .resetn_i(rstn), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .wr_valid_i(wv), .wr_ready_o(wrdy),
		.wr_data_i(wdat), .wr_last_i(wlast), .fetch_grant_o(grant), .burst_words_o(bw),
		.tx_start_o(start), .rd_valid_o(rv), .rd_ready_i(rrdy), .rd_data_o(rdat), .rd_last_o(rlast));
	txfb_far u_txfb_far (.sys_clk_i(clk), .resetn_i(rstn), .run_i(run), .drain_i(drain),
		.grant_i(grant), .wr_ready_i(wrdy), .wr_valid_o(wv), .wr_data_o(wdat),
		.wr_last_o(wlast), .rd_ready_o(rrdy));
	initial forever #4 clk = ~clk;
	task chk(input string n, input logic [32:0] s, input logic [32:0] e);
		n_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// One bus access, held until waitrequest is sampled low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		be <= b;
		for (i = 0; i < 20 && (i == 0 || wreq); i++)
			@(posedge clk);
		chk("waitrequest", wreq, 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk("readdata", q, e);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Note each word taken, compare each word delivered
	always @(posedge clk)
	begin
		if (wv && wrdy)
			exp_q.push_back({wlast, wdat});
		if (rv && rrdy)
			chk("mac word", {rlast, rdat}, exp_q.size() ? exp_q.pop_front() : 33'h0);
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rchk(TXFB_RX_DESC_PTR_OFS, 32'h0);
		rchk(TXFB_TX_CONFIG_OFS, 32'h0);
		c = $random(seed);
		bus(1'b1, TXFB_RX_DESC_PTR_OFS, c, 4'hF);
		rchk(TXFB_RX_DESC_PTR_OFS, c);
		// One byte lane only; the other lanes keep their value
		bus(1'b1, TXFB_RX_DESC_PTR_OFS, 32'hFFFF_FFFF, 4'h1);
		rchk(TXFB_RX_DESC_PTR_OFS, {c[31:8], 8'hFF});
		bus(1'b1, TXFB_SOFT_RESET_OFS, 32'h1, 4'hF);
		rchk(TXFB_RX_DESC_PTR_OFS, 32'h0);
		bus(1'b1, TXFB_TX_CONFIG_OFS, 32'hFFFF_FFFF, 4'hF);
		rchk(TXFB_TX_CONFIG_OFS, 32'h0070_3F3F);
		rchk(8'h04, TXFB_BAD_READ);
		// Each code; fill 512 bytes, drain 64 bytes
		for (c = 0; c < 8; c++)
		begin
			bus(1'b1, TXFB_TX_CONFIG_OFS, (c << 20) | 32'h0000_1002, 4'hF);
			repeat (3) @(posedge clk);
			chk("burst words", bw, c ? 1 << (c - 1) : 128);
		end
		// Fill with the MAC stalled until fetching is withheld
		run <= 1'b1;
		for (i = 0; i < 3000 && grant; i++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		chk("grant", grant, 1'b0);
		chk("tx start", start, 1'b1);
		// Every word taken has settled in the store; four words to a packet
		bus(1'b0, TXFB_STATUS_OFS, 32'h0, 4'hF);
		chk("byte count", q[11:0], exp_q.size() * 4);
		chk("packet count", q[31:24], exp_q.size() / 4);
		chk("free below fill", 2048 - q[11:0] < 512, 1'b1);
		// Drain with a random stall pattern
		run <= 1'b0;
		for (i = 0; i < 5000 && (rv || exp_q.size()); i++)
		begin
			@(posedge clk);
			c = $random(seed);
			drain <= c[0];
		end
		chk("drain done", rv, 1'b0);
		chk("words left", exp_q.size(), 0);
		print_verdict;
	end
endmodule // tx_fifo_threshold_burst_ctl_test
bind txfb_ctl txfb_ctl_props u_txfb_ctl_props (.sys_clk_i, .resetn_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
	.fetch_grant_o, .burst_words_o, .tx_start_o, .rd_valid_o, .rd_last_o);
`default_nettype wire
